// ### hdlc_tx_packet_engine.sv
// hdlc transmit packet engine, four ports, ahb-lite register slave
// Functional notes
// - space flag when free >= threshold*8+1
// - threshold field resets to sixteen
// - start disable stops after current packet
// - fcs inverted crc, error insert plain
// - fill flags or all ones between frames
// - lsb first, msb first when swapped
// - optional inversion of serial output
// - fcs disable sends packets without fcs
// - flush empties fifo, halts, drops writes
// - after flush drop until fresh packet start
// - data byte and end flag load together
// - free eight-byte groups in six bits
// - full only at maximum content
// - empty flag when no bytes stored
// - register set per port at bases 0,2,4,6
// - sticky flags on fifo events and rises
// - empty and space sticky on flush release
// - interrupt needs enable and port enable
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module hdlc_tx_packet_engine (
  input wire logic clock, // core clock
  input wire logic reset, // sync reset, high
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic [hdlc_tx_pkg::NPORTS-1:0] slot_enable, // bit slots
  input wire logic [hdlc_tx_pkg::NPORTS-1:0] port_status_irq_enable, // gate
  output logic [hdlc_tx_pkg::NPORTS-1:0] tx_serial, // serial out
  output logic [hdlc_tx_pkg::NPORTS-1:0] port_irq // per-port irq
);
  import hdlc_tx_pkg::*;

  // bus data phase tracking
  logic act_ff; // data phase open
  logic done_ff; // wait state passed
  logic wr_ff; // data phase is a write
  logic [11:0] idx_ff; // register index
  logic [31:0] hrdata_ff; // read data flop
  logic [15:0] rd_word [NPORTS]; // per-port read value

  wire logic accept = hsel && htrans[1] && hready;
  wire logic exec = act_ff && !done_ff;
  // port base digit 0,2,4,6 sits above the offset byte
  wire logic [1:0] port_sel = idx_ff[IDX_PORT_LSB+1:IDX_PORT_LSB];
  wire logic in_range = !idx_ff[11] && !idx_ff[8];
  wire logic [7:0] reg_ofs = idx_ff[7:0];
  wire logic wr_go = exec && wr_ff && in_range;
  wire logic rd_go = exec && !wr_ff;
  wire logic [15:0] wdat = hwdata[15:0];

  // every transfer takes one wait state, so read data can be a flop
  assign hreadyout = !exec;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // address phase capture
  always_ff @(posedge clock) begin
    if (reset) begin
      act_ff <= 1'b0;
      done_ff <= 1'b0;
      wr_ff <= 1'b0;
      idx_ff <= 12'h0;
    end else if (accept) begin
      act_ff <= 1'b1;
      done_ff <= 1'b0;
      wr_ff <= hwrite;
      idx_ff <= haddr[13:2];
    end else if (exec) begin
      done_ff <= 1'b1;
    end else begin
      act_ff <= 1'b0;
    end
  end

  // read data register; unmapped reads return zero
  always_ff @(posedge clock) begin
    if (reset) begin
      hrdata_ff <= 32'h0;
    end else if (rd_go) begin
      hrdata_ff <= in_range ? {16'h0, rd_word[port_sel]} : 32'h0;
    end
  end

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    // register strobes of this port
    wire logic sel = wr_go && port_sel == 2'(p);
    wire logic wr_ctrl = sel && reg_ofs == OFS_CTRL;
    wire logic wr_data = sel && reg_ofs == OFS_DATA;
    wire logic wr_stk = sel && reg_ofs == OFS_STICKY;
    wire logic wr_ie = sel && reg_ofs == OFS_IE;

    logic [15:0] ctrl_ff; // control register
    logic [15:0] ie_ff; // interrupt enables
    logic [15:0] sticky_ff; // latched events
    fifo_word_s mem [FIFO_DEPTH]; // fifo storage
    logic [7:0] wptr_ff; // write pointer
    logic [7:0] rptr_ff; // read pointer
    logic [8:0] count_ff; // bytes stored
    logic [3:0] wake_ff; // memory wake countdown
    logic partial_ff; // dropping rest of a packet
    logic flush_d_ff; // flush last cycle
    logic empty_d_ff; // empty last cycle
    logic space_d_ff; // space last cycle
    logic pop; // serializer takes a byte
    logic under; // serializer ran dry

    wire logic flush = ctrl_ff[CTL_FLUSH];
    wire logic waking = wake_ff != 4'h0;
    wire logic [4:0] thr = ctrl_ff[CTL_THR_LSB+4:CTL_THR_LSB];
    wire logic [8:0] free = 9'(FIFO_DEPTH) - count_ff;
    wire logic [9:0] need = {2'b0, thr, 3'b0} + 10'h1;
    wire logic space = {1'b0, free} >= need;
    wire logic [5:0] groups = free[8:3];
    wire logic empty = count_ff == 9'h0;
    wire logic full = count_ff == 9'(FIFO_DEPTH);
    // writes ignored in flush, dropped while waking or mid packet
    wire logic take = wr_data && !flush;
    wire logic drop = take && (waking || partial_ff);
    wire logic keep = take && !drop;
    wire logic push = keep && !full;
    wire logic over = keep && full;
    wire logic do_pop = pop && !empty;
    wire fifo_word_s head = mem[rptr_ff];
    wire logic [15:0] live = {2'b0, groups, 5'b0, full, empty, space};

    wire tx_mode_s mode = '{
      start_disable: ctrl_ff[CTL_PSD],
      fcs_err: ctrl_ff[CTL_FERR],
      fill_ones: ctrl_ff[CTL_FILL],
      msb_first: ctrl_ff[CTL_MSB],
      invert: ctrl_ff[CTL_INV],
      fcs_off: ctrl_ff[CTL_FCS_OFF]
    };

    // event set terms for the sticky register
    logic [15:0] set_bits;
    always_comb begin
      set_bits = 16'h0;
      set_bits[STK_OVER] = over;
      set_bits[STK_UNDER] = under;
      set_bits[STK_PEND] = do_pop && head.eop;
      set_bits[STK_EMPTY] = (empty && !empty_d_ff) ||
                            (flush_d_ff && !flush);
      set_bits[STK_SPACE] = (space && !space_d_ff) ||
                            (flush_d_ff && !flush);
    end

    // control and enable registers
    always_ff @(posedge clock) begin
      if (reset) begin
        ctrl_ff <= CTRL_RESET;
        ie_ff <= 16'h0;
      end else begin
        if (wr_ctrl) begin
          ctrl_ff <= wdat & CTRL_MASK;
        end
        if (wr_ie) begin
          ie_ff <= wdat & IE_MASK;
        end
      end
    end

    // sticky flags: write one clears, a new event wins
    always_ff @(posedge clock) begin
      if (reset) begin
        sticky_ff <= 16'h0;
      end else begin
        sticky_ff <= ((sticky_ff & ~(wr_stk ? wdat : 16'h0)) |
                      set_bits) & STICKY_MASK;
      end
    end

    // history for edge detection
    always_ff @(posedge clock) begin
      if (reset) begin
        flush_d_ff <= 1'b0;
        empty_d_ff <= 1'b1;
        space_d_ff <= 1'b1;
      end else begin
        flush_d_ff <= flush;
        empty_d_ff <= empty;
        space_d_ff <= space;
      end
    end

    // wake countdown and partial packet drop
    always_ff @(posedge clock) begin
      if (reset || flush) begin
        wake_ff <= 4'(WAKE_CYCLES);
        partial_ff <= 1'b0;
      end else begin
        if (waking) begin
          wake_ff <= wake_ff - 4'h1;
        end
        if (drop) begin
          partial_ff <= !wdat[DAT_EOP];
        end
      end
    end

    // fifo pointers and level; flush empties it
    always_ff @(posedge clock) begin
      if (reset || flush) begin
        wptr_ff <= 8'h0;
        rptr_ff <= 8'h0;
        count_ff <= 9'h0;
      end else begin
        if (push) begin
          wptr_ff <= wptr_ff + 8'h1;
        end
        if (do_pop) begin
          rptr_ff <= rptr_ff + 8'h1;
        end
        count_ff <= count_ff + 9'(push) - 9'(do_pop);
      end
    end

    // storage has no reset; only written words are read
    always_ff @(posedge clock) begin
      if (push) begin
        mem[wptr_ff] <= '{data: wdat[DAT_BYTE_LSB+7:DAT_BYTE_LSB],
                          eop: wdat[DAT_EOP]};
      end
    end

    // read mux; data port reads as zero
    always_comb begin
      unique case (reg_ofs)
        OFS_CTRL: rd_word[p] = ctrl_ff;
        OFS_LIVE: rd_word[p] = live;
        OFS_STICKY: rd_word[p] = sticky_ff;
        OFS_IE: rd_word[p] = ie_ff;
        default: rd_word[p] = 16'h0;
      endcase
    end

    // irq also needs the port-level enable from outside
    assign port_irq[p] = |(sticky_ff & ie_ff) &&
                         port_status_irq_enable[p];

    hdlc_bit_serializer u_ser (
      .clock(clock),
      .reset(reset),
      .hold(flush),
      .slot_en(slot_enable[p]),
      .mode(mode),
      .byte_ok(!empty),
      .byte_in(head),
      .pop(pop),
      .underflow(under),
      .tx_bit(tx_serial[p])
    );

    a_space_level: assert property (@(posedge clock) disable iff (reset)
      live[LIV_SPACE] == (free > {thr, 3'b0}))
      else $error("space flag wrong");
    a_full_reach: assert property (@(posedge clock) disable iff (reset)
      count_ff == 9'hff && push && !do_pop |=> live[LIV_FULL])
      else $error("full not set at maximum");
    a_groups_free: assert property (@(posedge clock) disable iff (reset)
      {1'b0, groups, 3'b0} <= {1'b0, free} &&
      {1'b0, free} < {1'b0, groups, 3'b0} + 10'h8)
      else $error("free groups wrong");
    a_flush_empty: assert property (@(posedge clock) disable iff (reset)
      flush ##1 wr_data |=> live[LIV_EMPTY] && count_ff == 9'h0)
      else $error("flush did not empty");
    a_release_sticky: assert property (@(posedge clock)
      disable iff (reset)
      $fell(flush) |=> sticky_ff[STK_EMPTY] && sticky_ff[STK_SPACE])
      else $error("release did not latch");
    a_wake_drop: assert property (@(posedge clock) disable iff (reset)
      waking && wr_data |=> count_ff == $past(count_ff))
      else $error("write kept while waking");
    a_over_latch: assert property (@(posedge clock) disable iff (reset)
      over |=> sticky_ff[STK_OVER] && count_ff == 9'(FIFO_DEPTH))
      else $error("overflow not latched");
    a_irq_gate: assert property (@(posedge clock) disable iff (reset)
      port_irq[p] |-> port_status_irq_enable[p] &&
                      (sticky_ff & ie_ff) != 16'h0)
      else $error("irq without enables");
  end

  a_data_reads_zero: assert property (@(posedge clock)
    disable iff (reset)
    rd_go && reg_ofs == OFS_DATA |=> hrdata == 32'h0)
    else $error("data port read nonzero");
  a_reset_thr: assert property (@(posedge clock)
    $past(reset) && !reset |->
    g_port[0].thr == 5'h10)
    else $error("threshold reset value wrong");
endmodule
`default_nettype wire

// ### hdlc_tx_pkg.sv
// constants and carriers for the hdlc transmit packet engine
package hdlc_tx_pkg;
  localparam int NPORTS = 4;
  // register indices within one port block
  localparam logic [7:0] OFS_CTRL = 8'ha0;
  localparam logic [7:0] OFS_DATA = 8'ha2;
  localparam logic [7:0] OFS_LIVE = 8'ha4;
  localparam logic [7:0] OFS_STICKY = 8'ha6;
  localparam logic [7:0] OFS_IE = 8'ha8;
  localparam int IDX_PORT_LSB = 9;
  // control fields
  localparam int CTL_FLUSH = 0;
  localparam int CTL_FCS_OFF = 1;
  localparam int CTL_INV = 2;
  localparam int CTL_MSB = 3;
  localparam int CTL_FILL = 4;
  localparam int CTL_FERR = 5;
  localparam int CTL_PSD = 6;
  localparam int CTL_THR_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  localparam logic [15:0] CTRL_MASK = 16'h1f7f;
  // data port fields
  localparam int DAT_EOP = 0;
  localparam int DAT_BYTE_LSB = 8;
  // live status fields
  localparam int LIV_SPACE = 0;
  localparam int LIV_EMPTY = 1;
  localparam int LIV_FULL = 2;
  localparam int LIV_GROUPS_LSB = 8;
  // sticky status fields
  localparam int STK_SPACE = 0;
  localparam int STK_EMPTY = 1;
  localparam int STK_PEND = 3;
  localparam int STK_UNDER = 4;
  localparam int STK_OVER = 5;
  localparam logic [15:0] STICKY_MASK = 16'h003b;
  localparam logic [15:0] IE_MASK = 16'h003f;
  // fifo and line constants
  localparam int FIFO_DEPTH = 256;
  localparam logic [7:0] FLAG_OCTET = 8'h7e;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  // memory wake time after flush release
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_TIME_NS = 64;
  localparam int WAKE_CYCLES =
    (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef struct packed {
    logic start_disable;
    logic fcs_err;
    logic fill_ones;
    logic msb_first;
    logic invert;
    logic fcs_off;
  } tx_mode_s;
  typedef struct packed {
    logic [7:0] data;
    logic eop;
  } fifo_word_s;
endpackage

// ### hdlc_bit_serializer.sv
// hdlc bit serializer: flags, zero insertion, crc-16 fcs
`timescale 1ns/100ps
`default_nettype none
module hdlc_bit_serializer (
  input wire logic clock, // core clock
  input wire logic reset, // sync reset, high
  input wire logic hold, // flush: halt and idle
  input wire logic slot_en, // one bit slot
  input wire hdlc_tx_pkg::tx_mode_s mode, // mode bits
  input wire logic byte_ok, // fifo not empty
  input wire hdlc_tx_pkg::fifo_word_s byte_in, // fifo head
  output logic pop, // take fifo head
  output logic underflow, // ran dry mid packet
  output logic tx_bit // serial out
);
  import hdlc_tx_pkg::*;
  typedef enum logic [2:0] {
    S_FILL, S_OPEN, S_DATA, S_FCS, S_CLOSE
  } ser_state_e;
  ser_state_e st_ff; // line state
  logic [15:0] sh_ff; // outgoing bits
  logic [3:0] cnt_ff; // bit index
  logic [2:0] ones_ff; // run of ones
  logic stuff_ff; // zero owed
  logic eop_ff; // byte in flight ends packet
  logic [15:0] crc_ff; // running crc
  logic out_ff; // output flop
  logic raw; // bit before inversion
  wire logic flag_bit = FLAG_OCTET[cnt_ff[2:0]];
  wire logic in_frame = st_ff == S_DATA || st_ff == S_FCS;
  wire logic step = slot_en && !stuff_ff;
  wire logic last = st_ff == S_FCS ? cnt_ff == 4'hf : cnt_ff == 4'h7;
  wire logic tick = step && last;
  wire logic fb = crc_ff[0] ^ sh_ff[0];
  wire logic [15:0] nxt_crc = (crc_ff >> 1) ^ (fb ? CRC_POLY_REV : 16'h0);
  // inverted crc normally, plain crc for error insertion
  wire logic [15:0] fcs = mode.fcs_err ? nxt_crc : ~nxt_crc;
  wire logic [7:0] rev = {<<{byte_in.data}};
  wire logic [7:0] ordered = mode.msb_first ? rev : byte_in.data;
  wire logic load_open = st_ff == S_OPEN && byte_ok;
  wire logic load_next = st_ff == S_DATA && !eop_ff && byte_ok;
  assign pop = tick && (load_open || load_next);
  assign underflow = tick && st_ff == S_DATA && !eop_ff && !byte_ok;
  assign tx_bit = out_ff;
  // pick the line bit for this slot
  always_comb begin
    unique case (st_ff)
      S_FILL: raw = mode.fill_ones ? 1'b1 : flag_bit;
      S_OPEN, S_CLOSE: raw = flag_bit;
      S_DATA, S_FCS: raw = sh_ff[0];
      default: raw = 1'b1; // unused codes idle high
    endcase
    if (stuff_ff) begin
      raw = 1'b0;
    end
  end
  // state, shifter and counters
  always_ff @(posedge clock) begin
    if (reset || hold) begin
      st_ff <= S_FILL;
      cnt_ff <= 4'h0;
      sh_ff <= 16'h0;
      eop_ff <= 1'b0;
      crc_ff <= CRC_INIT;
    end else if (step) begin
      cnt_ff <= last ? 4'h0 : cnt_ff + 4'h1;
      if (in_frame) begin
        sh_ff <= sh_ff >> 1;
      end
      if (st_ff == S_DATA) begin
        crc_ff <= nxt_crc;
      end
      if (last) begin
        unique case (st_ff)
          S_FILL: if (byte_ok && !mode.start_disable) begin
            st_ff <= S_OPEN;
          end
          S_OPEN: if (byte_ok) begin
            st_ff <= S_DATA;
            sh_ff <= {8'h0, ordered};
            eop_ff <= byte_in.eop;
            crc_ff <= CRC_INIT;
          end else begin
            st_ff <= S_FILL;
          end
          S_DATA: if (eop_ff && mode.fcs_off) begin
            st_ff <= S_CLOSE;
          end else if (eop_ff) begin
            st_ff <= S_FCS;
            sh_ff <= fcs;
          end else if (byte_ok) begin
            sh_ff <= {8'h0, ordered};
            eop_ff <= byte_in.eop;
          end else begin
            st_ff <= S_CLOSE; // short packet is closed at once
          end
          S_FCS: st_ff <= S_CLOSE;
          S_CLOSE: st_ff <= S_FILL;
        endcase
      end
    end
  end
  // zero insertion after five ones inside frame and fcs
  always_ff @(posedge clock) begin
    if (reset || hold) begin
      ones_ff <= 3'h0;
      stuff_ff <= 1'b0;
    end else if (slot_en) begin
      if (stuff_ff || !in_frame || !raw) begin
        ones_ff <= 3'h0;
        stuff_ff <= 1'b0;
      end else begin
        ones_ff <= ones_ff + 3'h1;
        stuff_ff <= ones_ff == 3'h4;
      end
    end
  end
  // output flop, optional inversion
  always_ff @(posedge clock) begin
    if (reset) begin
      out_ff <= 1'b1;
    end else if (slot_en) begin
      out_ff <= raw ^ mode.invert;
    end
  end
  sequence s_fcs_end;
    st_ff == S_DATA && tick && eop_ff && !hold;
  endsequence
  a_fcs_skip: assert property (@(posedge clock) disable iff (reset)
    s_fcs_end ##0 mode.fcs_off |=> st_ff == S_CLOSE)
    else $error("fcs not skipped");
  a_stuff_zero: assert property (@(posedge clock) disable iff (reset)
    stuff_ff && slot_en |=> tx_bit == $past(mode.invert))
    else $error("stuffed bit not zero");
  a_psd_hold: assert property (@(posedge clock) disable iff (reset)
    st_ff == S_FILL && mode.start_disable |=> st_ff == S_FILL)
    else $error("packet started while disabled");
  a_fill_ones: assert property (@(posedge clock) disable iff (reset)
    st_ff == S_FILL && mode.fill_ones && slot_en && !stuff_ff
    |=> tx_bit == !$past(mode.invert))
    else $error("fill not all ones");
endmodule
`default_nettype wire

// ### hdlc_line_partner.sv
// line-side partner: overhead slot source and serial bit capture
`timescale 1ns/100ps
`default_nettype none
module hdlc_line_partner (
  input wire logic clock, // core clock
  input wire logic reset, // sync reset, high
  input wire logic [3:0] gap, // cycles between slots, two or more
  input wire logic [hdlc_tx_pkg::NPORTS-1:0] tx_serial, // engine bits
  output logic [hdlc_tx_pkg::NPORTS-1:0] slot_enable // slot pulses
);
  import hdlc_tx_pkg::*;
  logic [3:0] cnt_ff; // slot spacing count
  logic dly_ff; // slot seen last edge
  logic rx0 [$]; // port 0 bits in line order
  // every port gets the same one-cycle slot pattern
  assign slot_enable = {NPORTS{cnt_ff == 4'h0}};
  // spacing counter; a wider gap models a slow framer
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_ff <= 4'h0;
      dly_ff <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff >= gap - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
      dly_ff <= slot_enable[0];
    end
  end
  // bit moves one edge after its slot, so take it one edge later
  always @(posedge clock) begin
    if (dly_ff) begin
      rx0.push_back(tx_serial[0]);
    end
  end
endmodule
`default_nettype wire

// ### hdlc_tx_packet_engine_tb.sv
// self-checking bench for the hdlc transmit packet engine
`timescale 1ns/100ps
`default_nettype none
module hdlc_tx_packet_engine_tb;
  import hdlc_tx_pkg::*;
  logic clock = 1'b0; // core clock
  logic reset = 1'b1; // sync reset, high
  logic hsel = 1'b0; // slave select
  logic hwrite = 1'b0; // write strobe
  logic [1:0] htrans = 2'h0; // transfer type
  logic [2:0] hsize = 3'h2; // word transfers only
  logic [31:0] haddr = 32'h0; // byte address
  logic [31:0] hwdata = 32'h0; // write data
  logic hreadyout; // slave ready, fed back as bus ready
  logic [31:0] hrdata; // read data
  logic hresp; // bus response, always okay
  logic [NPORTS-1:0] port_ie = 4'h0; // per-port irq gate
  logic [NPORTS-1:0] slot_enable; // from line partner
  logic [NPORTS-1:0] tx_serial; // to line partner
  logic [NPORTS-1:0] port_irq; // per-port interrupt
  logic [3:0] gap = 4'h3; // slot spacing, prompt first
  logic [31:0] rd; // last read word
  logic exp_q [$]; // expected line bits of one frame
  int fails = 0; // mismatches
  int n_compared = 0; // comparisons
  always #4 clock = ~clock;
  hdlc_tx_packet_engine uut (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .slot_enable(slot_enable),
    .port_status_irq_enable(port_ie), .tx_serial(tx_serial),
    .port_irq(port_irq)
  );
  hdlc_line_partner u_line (
    .clock(clock), .reset(reset), .gap(gap), .tx_serial(tx_serial),
    .slot_enable(slot_enable)
  );
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // port p sits at base 2p, index times four
  function automatic logic [31:0] ra(input int p, input logic [7:0] o);
    return {19'h0, p[1:0], 1'b0, o, 2'h0};
  endfunction
  // one single transfer; waits on ready, never on a cycle count
  task automatic bus(input logic w, input int p, input logic [7:0] o,
                     input logic [15:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= ra(p, o);
    // address phase stands until ready is seen high at an edge
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    // data phase ends, and read data is taken, at the next ready edge
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic wr(input int p, input logic [7:0] o, input logic [15:0] d);
    bus(1'b1, p, o, d);
  endtask
  task automatic rchk(input int p, input logic [7:0] o,
                      input logic [31:0] exp);
    bus(1'b0, p, o, 16'h0);
    check(rd, exp);
  endtask
  // byte and end mark go in one write
  task automatic push(input int p, input logic [7:0] b, input logic e);
    wr(p, OFS_DATA, {b, 7'h0, e});
  endtask
  task automatic irq_chk(input logic [3:0] exp);
    @(negedge clock);
    check({28'h0, port_irq}, {28'h0, exp});
  endtask
  // flag, stuffed byte and fcs, flag; crc runs over line-order bits
  task automatic expect_frame(input logic [7:0] b, input logic msb,
                              input logic fcs, input logic ferr);
    logic raw [$];
    logic [15:0] crc;
    int k;
    int ones;
    crc = CRC_INIT;
    for (k = 0; k < 8; k++) raw.push_back(msb ? b[7-k] : b[k]);
    for (k = 0; k < 8; k++)
      crc = (crc >> 1) ^ ((crc[0] ^ raw[k]) ? CRC_POLY_REV : 16'h0);
    if (!ferr) crc = ~crc;
    if (fcs) for (k = 0; k < 16; k++) raw.push_back(crc[k]);
    exp_q = {};
    for (k = 0; k < 8; k++) exp_q.push_back(FLAG_OCTET[k]);
    ones = 0;
    for (k = 0; k < raw.size(); k++) begin
      exp_q.push_back(raw[k]);
      ones = raw[k] ? ones + 1 : 0;
      if (ones == 5) begin
        exp_q.push_back(1'b0);
        ones = 0;
      end
    end
    for (k = 0; k < 8; k++) exp_q.push_back(FLAG_OCTET[k]);
  endtask
  // look for the expected frame in captured bits, bounded wait
  task automatic see_frame(input int from);
    int t;
    int s;
    int k;
    logic hit;
    hit = 1'b0;
    for (t = 0; t < 800 && !hit; t++) begin
      @(negedge clock);
      for (s = from; s + exp_q.size() <= u_line.rx0.size() && !hit;
           s++) begin
        hit = 1'b1;
        for (k = 0; k < exp_q.size(); k++)
          if (u_line.rx0[s+k] !== exp_q[k]) hit = 1'b0;
      end
    end
    check({31'h0, hit}, 32'h1);
  endtask
  // reset values, read-only zeros, unused offsets
  task automatic t_reset;
    rchk(0, OFS_CTRL, 32'h1000);
    rchk(3, OFS_IE, 32'h0);
    rchk(0, OFS_STICKY, 32'h0);
    rchk(2, OFS_LIVE, 32'h2003);
    rchk(0, OFS_DATA, 32'h0);
    wr(0, 8'haa, 16'hffff);
    rchk(0, 8'haa, 32'h0);
    check({31'h0, hresp}, 32'h0);
  endtask
  // fill port 1 with start held off, then overflow and flush
  task automatic t_levels;
    int i;
    wr(1, OFS_CTRL, 16'h1040);
    for (i = 0; i < 127; i++) push(1, i[7:0], 1'b0);
    rchk(1, OFS_LIVE, 32'h1001);
    push(1, 8'h7f, 1'b0);
    rchk(1, OFS_LIVE, 32'h1000);
    for (i = 128; i < 255; i++) push(1, i[7:0], 1'b0);
    rchk(1, OFS_LIVE, 32'h0000);
    push(1, 8'hff, 1'b1);
    rchk(1, OFS_LIVE, 32'h0004);
    push(1, 8'hee, 1'b1); // one too many
    rchk(1, OFS_STICKY, 32'h20);
    wr(1, OFS_CTRL, 16'h1041);
    push(1, 8'h55, 1'b1); // ignored while flushing
    rchk(1, OFS_LIVE, 32'h2003);
    wr(1, OFS_STICKY, 16'h003f);
    wr(1, OFS_CTRL, 16'h1f40); // release, threshold 31
    push(1, 8'h11, 1'b0); // lands during memory wake
    push(1, 8'h22, 1'b1); // closes the dropped packet
    rchk(1, OFS_LIVE, 32'h2003);
    rchk(1, OFS_STICKY, 32'h03);
    for (i = 0; i < 7; i++) push(1, 8'h33, 1'b0);
    rchk(1, OFS_LIVE, 32'h1f01);
    push(1, 8'h44, 1'b0);
    rchk(1, OFS_LIVE, 32'h1f00);
  endtask
  // sticky empty on port 1 through its enable and the port gate
  task automatic t_irq;
    wr(1, OFS_IE, 16'h0002);
    irq_chk(4'h0);
    @(posedge clock);
    port_ie <= 4'h2;
    irq_chk(4'h2);
    wr(1, OFS_IE, 16'h0020);
    irq_chk(4'h0);
    wr(1, OFS_IE, 16'h0002);
    irq_chk(4'h2);
    wr(1, OFS_STICKY, 16'h0002);
    irq_chk(4'h0);
    rchk(1, OFS_IE, 32'h0002);
  endtask
  // frames on port 0 over each order and fcs mode
  task automatic t_frames;
    logic [15:0] mode [4] = '{16'h1000, 16'h100a, 16'h1020, 16'h1022};
    logic [7:0] dat [4] = '{8'hff, 8'h01, 8'h01, 8'h3c};
    int i;
    int n;
    for (i = 0; i < 4; i++) begin
      gap <= (i < 2) ? 4'h3 : 4'h7; // prompt, then slow slots
      wr(0, OFS_CTRL, mode[i]);
      expect_frame(dat[i], mode[i][CTL_MSB], !mode[i][CTL_FCS_OFF],
                   mode[i][CTL_FERR]);
      n = u_line.rx0.size();
      push(0, dat[i], 1'b1);
      see_frame(n);
    end
    rchk(0, OFS_STICKY, 32'h0a);
    push(0, 8'h00, 1'b0); // no end mark, so it runs dry
    rd = 32'h0;
    for (i = 0; i < 200 && rd[STK_UNDER] !== 1'b1; i++)
      bus(1'b0, 0, OFS_STICKY, 16'h0);
    check(rd & 32'h10, 32'h10);
  endtask
  // fill of all ones, plain and inverted, on every port; port 1 keeps
  // start disable set, so its stored bytes must stay put
  task automatic t_fill;
    logic [15:0] mode [2] = '{16'h1010, 16'h1014};
    int i;
    int k;
    int n;
    for (i = 0; i < 2; i++) begin
      for (k = 0; k < NPORTS; k++)
        wr(k, OFS_CTRL, mode[i] | (k == 1 ? 16'h0040 : 16'h0000));
      n = u_line.rx0.size();
      for (k = 0; k < 900 && u_line.rx0.size() < n + 32; k++)
        @(negedge clock);
      for (k = n + 16; k < n + 32; k++)
        check({31'h0, u_line.rx0[k]}, {31'h0, !mode[i][CTL_INV]});
      check({28'h0, tx_serial}, {28'h0, {4{!mode[i][CTL_INV]}}});
    end
    rchk(1, OFS_LIVE, 32'h1f01);
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_levels;
    t_irq;
    t_frames;
    t_fill;
    tally_and_finish;
  end
  // hang guard, well beyond the few thousand cycles expected
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
